// ### hdl/spm_pkg.sv
// spm_pkg: register map, field positions and constants of the SPI master
package spm_pkg;
	// ------------------------------------------------------------------
	// register indices (byte address = 4 * index, low eight bits decoded)
	// ------------------------------------------------------------------
	localparam logic [31:0] SPM_IDX_CTRL = 32'h5000001C;
	localparam logic [31:0] SPM_IDX_STAT = 32'h5000001D;
	localparam logic [31:0] SPM_IDX_DATA = 32'h5000001E;
	localparam logic [31:0] SPM_IDX_EXT  = 32'h5000001F;
	localparam logic [31:0] SPM_IDX_MASK = 32'h50000020;
	localparam int          SPM_IDX_LSB  = 2;
	localparam int          SPM_IDX_W    = 8;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int SPM_CTRL_IRQEN = 7;
	localparam int SPM_CTRL_MSEL  = 4;
	localparam int SPM_CTRL_CLOCK_IDLE_LEVEL  = 3;
	localparam int SPM_CTRL_CLOCK_SAMPLE_EDGE  = 2;
	localparam int SPM_CTRL_STD   = 0;
	localparam int SPM_STAT_FLAG  = 7;
	localparam int SPM_STAT_WCOL  = 6;
	localparam int SPM_STAT_TXF   = 3;
	localparam int SPM_STAT_TXE   = 2;
	localparam int SPM_STAT_RXF   = 1;
	localparam int SPM_STAT_RXE   = 0;
	localparam int SPM_EXT_CNT    = 6;
	localparam int SPM_EXT_EN     = 2;
	localparam int SPM_EXT_DIV    = 0;

	// ------------------------------------------------------------------
	// reset values, write masks, encodings
	// ------------------------------------------------------------------
	localparam logic [7:0] SPM_CTRL_RST   = 8'h10;
	localparam logic [7:0] SPM_CTRL_WMASK = 8'h8F;
	localparam logic [7:0] SPM_EXT_RST    = 8'h00;
	localparam logic [7:0] SPM_EXT_WMASK  = 8'hC7;
	localparam logic [7:0] SPM_MASK_RST   = 8'hC0;
	localparam logic [1:0] SPM_DIV_RSVD   = 2'h3;
	localparam int         SPM_FIFO_DEPTH = 4;
	localparam int         SPM_BYTE_W     = 8;
	localparam logic [3:0] SPM_LAST_EDGE  = 4'hF;

	// log2 of the clock divider, indexed by {extended, standard} select
	localparam logic [11:0][3:0] SPM_DIV_EXP = {
		4'hC, 4'hB, 4'hA, 4'h9,
		4'h8, 4'h7, 4'h6, 4'h3,
		4'h5, 4'h4, 4'h2, 4'h1
	};
endpackage

// ### hdl/spm_fifo.sv
// spm_fifo: small synchronous byte FIFO with full and empty flags
module spm_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         clk,   // system clock
	input  wire logic         rst_n, // async reset, active low
	input  wire logic         push,  // write strobe, ignored when full
	input  wire logic [W-1:0] wdata, // write data
	input  wire logic         pop,   // read strobe, ignored when empty
	output logic      [W-1:0] rdata, // head entry
	output logic              full,  // no room left
	output logic              empty  // nothing stored
);
	// D must be a power of two so the pointers wrap by themselves
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} spm_fifo_st_t;

	spm_fifo_st_t q;
	spm_fifo_st_t n;
	logic         do_push;
	logic         do_pop;

	always_comb begin
		n       = q;
		full    = q.cnt == (AW+1)'(D);
		empty   = q.cnt == '0;
		rdata   = q.mem[q.rp];
		do_push = push && !full;
		do_pop  = pop && !empty;
		if (do_push) begin
			n.mem[q.wp] = wdata;
			n.wp        = q.wp + 1'b1;
		end
		if (do_pop) begin
			n.rp = q.rp + 1'b1;
		end
		case ({do_push, do_pop})
			2'b10: n.cnt = q.cnt + 1'b1;
			2'b01: n.cnt = q.cnt - 1'b1;
			default: n.cnt = q.cnt;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule // spm_fifo

// ### hdl/spm_spi_master.sv
// spm_spi_master: SPI master with byte FIFOs, AHB-Lite registers and interrupt
//
// Function
// - irq_enable gates the interrupt; when set, interrupt follows the flag and write_collision, each under its mask bit.
// - master_select reads one, read-only; control resets to 0x10.
// - phase clear samples leaving idle, shifts returning; set swaps the edges.
// - serial clock is system clock divided by standard and extended selects.
// - status top bit shows the interrupt flag.
// - data write while transmit FIFO full sets write_collision.
// - status shows transmit FIFO full and empty.
// - status shows receive FIFO full and empty.
// - interrupt flag set after every one to four completed transfers.
// - module_enable clear keeps the controller inactive; resets to zero.
// - clock_idle_level sets the serial clock idle level.
// - writing the data register queues a byte in a four-deep transmit FIFO.
// - each received byte goes to a four-deep receive FIFO.
//
// The AHB-Lite register port was decided locally.
module spm_spi_master (
	input  wire logic        clk,       // system clock, 100 MHz
	input  wire logic        rst_n,     // async reset, active low
	input  wire logic        hsel,      // slave select
	input  wire logic [31:0] haddr,     // byte address
	input  wire logic [1:0]  htrans,    // transfer type
	input  wire logic        hwrite,    // write when high
	input  wire logic [2:0]  hsize,     // word only
	input  wire logic [31:0] hwdata,    // write data
	input  wire logic        hready,    // bus ready
	output logic      [31:0] hrdata,    // read data
	output logic             hreadyout, // slave ready
	output logic             hresp,     // always okay
	output logic             irq,       // level interrupt, active high
	output logic             spi_sclk,  // serial clock
	output logic             spi_mosi,  // serial data out
	input  wire logic        spi_miso   // serial data in
);
	import spm_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  ext;
		logic [7:0]  mask;
		logic        irq_flag;
		logic        wcol;
		logic [1:0]  xfer_cnt;
		logic        wr_pend;
		logic        rd_pend;
		logic [7:0]  idx;
		logic        hready;
		logic        hresp;
		logic [31:0] hrdata;
		logic        irq;
		logic        busy;
		logic        sclk;
		logic        mosi;
		logic [7:0]  txsh;
		logic [7:0]  rxsh;
		logic [11:0] hcnt;
		logic [3:0]  edge_n;
	} spm_core_st_t;

	spm_core_st_t q;
	spm_core_st_t n;
	logic         acc;
	logic         wr_data;
	logic         rd_data;
	logic         tx_push;
	logic         tx_pop;
	logic         rx_push;
	logic         rx_pop;
	logic         evt_wcol;
	logic         evt_cnt;
	logic         done;
	logic         clock_sample_edge;
	logic         tx_full;
	logic         tx_empty;
	logic         rx_full;
	logic         rx_empty;
	logic [7:0]   tx_rdata;
	logic [7:0]   rx_rdata;
	logic [7:0]   rd_val;
	logic [3:0]   div_exp;
	logic [11:0]  half_lim;

	// ------------------------------------------------------------------
	// byte FIFOs
	// ------------------------------------------------------------------
	spm_fifo #(.W(SPM_BYTE_W), .D(SPM_FIFO_DEPTH)) u_tx_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.push  (tx_push),
		.wdata (hwdata[7:0]),
		.pop   (tx_pop),
		.rdata (tx_rdata),
		.full  (tx_full),
		.empty (tx_empty)
	);

	spm_fifo #(.W(SPM_BYTE_W), .D(SPM_FIFO_DEPTH)) u_rx_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.push  (rx_push),
		.wdata (n.rxsh),
		.pop   (rx_pop),
		.rdata (rx_rdata),
		.full  (rx_full),
		.empty (rx_empty)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		n        = q;
		acc      = hsel && htrans[1] && hready;
		wr_data  = q.wr_pend && q.idx == SPM_IDX_DATA[7:0];
		rd_data  = q.rd_pend && q.idx == SPM_IDX_DATA[7:0];
		tx_push  = wr_data && !tx_full;
		evt_wcol = wr_data && tx_full;
		rx_pop   = rd_data && !rx_empty;
		tx_pop   = 1'b0;
		rx_push  = 1'b0;
		done     = 1'b0;
		evt_cnt  = 1'b0;
		clock_sample_edge     = q.ctrl[SPM_CTRL_CLOCK_SAMPLE_EDGE];
		div_exp  = 4'h1;
		if ({q.ext[SPM_EXT_DIV +: 2], q.ctrl[SPM_CTRL_STD +: 2]} < 4'hC) begin
			div_exp = SPM_DIV_EXP[{q.ext[SPM_EXT_DIV +: 2], q.ctrl[SPM_CTRL_STD +: 2]}];
		end
		half_lim = (12'h1 << (div_exp - 4'h1)) - 12'h1;

		// read mux; reserved bits read zero
		rd_val = '0;
		case (q.idx)
			SPM_IDX_CTRL[7:0]: rd_val = q.ctrl;
			SPM_IDX_STAT[7:0]: begin
				rd_val[SPM_STAT_FLAG] = q.irq_flag;
				rd_val[SPM_STAT_WCOL] = q.wcol;
				rd_val[SPM_STAT_TXF]  = tx_full;
				rd_val[SPM_STAT_TXE]  = tx_empty;
				rd_val[SPM_STAT_RXF]  = rx_full;
				rd_val[SPM_STAT_RXE]  = rx_empty;
			end
			SPM_IDX_DATA[7:0]: rd_val = rx_rdata;
			SPM_IDX_EXT[7:0]:  rd_val = q.ext;
			SPM_IDX_MASK[7:0]: rd_val = q.mask;
			default:           rd_val = '0;
		endcase

		// bus: writes are zero-wait, reads take one wait state so that a
		// read right behind a write already sees the written value
		n.hresp   = 1'b0;
		n.hready  = !(acc && !hwrite);
		n.wr_pend = acc && hwrite;
		n.rd_pend = acc && !hwrite;
		if (acc) begin
			n.idx = haddr[SPM_IDX_LSB +: SPM_IDX_W];
		end
		if (q.rd_pend) begin
			n.hrdata = {24'h000000, rd_val};
		end
		if (q.wr_pend) begin
			case (q.idx)
				SPM_IDX_CTRL[7:0]: n.ctrl = (hwdata[7:0] & SPM_CTRL_WMASK) | SPM_CTRL_RST;
				SPM_IDX_EXT[7:0]:  n.ext  = hwdata[7:0] & SPM_EXT_WMASK;
				SPM_IDX_MASK[7:0]: n.mask = hwdata[7:0];
				SPM_IDX_STAT[7:0]: begin
					if (hwdata[SPM_STAT_FLAG]) begin
						n.irq_flag = 1'b0;
					end
					if (hwdata[SPM_STAT_WCOL]) begin
						n.wcol = 1'b0;
					end
				end
				default: n.ctrl = q.ctrl;
			endcase
		end

		// shift engine
		if (!q.busy) begin
			n.hcnt   = '0;
			n.edge_n = '0;
			// a full receive FIFO stalls the next byte instead of losing one
			if (q.ext[SPM_EXT_EN] && q.ext[SPM_EXT_DIV +: 2] != SPM_DIV_RSVD
			    && !tx_empty && !rx_full) begin
				tx_pop = 1'b1;
				n.busy = 1'b1;
				n.txsh = tx_rdata;
				if (!clock_sample_edge) begin
					n.mosi = tx_rdata[7];
					n.txsh = {tx_rdata[6:0], 1'b0};
				end
			end
		end else if (q.hcnt != half_lim) begin
			n.hcnt = q.hcnt + 12'h1;
		end else begin
			n.hcnt   = '0;
			n.sclk   = !q.sclk;
			n.edge_n = q.edge_n + 4'h1;
			// even edges leave the idle level
			if (q.edge_n[0] == clock_sample_edge) begin
				n.rxsh = {q.rxsh[6:0], spi_miso};
			end else begin
				n.mosi = q.txsh[7];
				n.txsh = {q.txsh[6:0], 1'b0};
			end
			if (q.edge_n == SPM_LAST_EDGE) begin
				n.busy  = 1'b0;
				done    = 1'b1;
				rx_push = 1'b1;
			end
		end
		if (!n.busy) begin
			n.sclk = n.ctrl[SPM_CTRL_CLOCK_IDLE_LEVEL];
		end

		// coalescing counter
		if (done) begin
			if (q.xfer_cnt == q.ext[SPM_EXT_CNT +: 2]) begin
				evt_cnt    = 1'b1;
				n.xfer_cnt = '0;
			end else begin
				n.xfer_cnt = q.xfer_cnt + 2'h1;
			end
		end

		// set wins over a clear in the same cycle
		if (evt_cnt) begin
			n.irq_flag = 1'b1;
		end
		if (evt_wcol) begin
			n.wcol = 1'b1;
		end
		n.irq = n.ctrl[SPM_CTRL_IRQEN]
		        && ((n.irq_flag && n.mask[SPM_STAT_FLAG])
		        || (n.wcol && n.mask[SPM_STAT_WCOL]));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q        <= '0;
			q.ctrl   <= SPM_CTRL_RST;
			q.ext    <= SPM_EXT_RST;
			q.mask   <= SPM_MASK_RST;
			q.hready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign hrdata    = q.hrdata;
	assign hreadyout = q.hready;
	assign hresp     = q.hresp;
	assign irq       = q.irq;
	assign spi_sclk  = q.sclk;
	assign spi_mosi  = q.mosi;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	irq_gate_a: assert property (
		irq == (q.ctrl[SPM_CTRL_IRQEN] && ((q.irq_flag && q.mask[SPM_STAT_FLAG])
		        || (q.wcol && q.mask[SPM_STAT_WCOL]))))
		else $error("interrupt output does not follow enable and flags");

	master_bit_a: assert property (
		q.rd_pend && q.idx == SPM_IDX_CTRL[7:0] |=> hreadyout && hrdata[SPM_CTRL_MSEL])
		else $error("master select bit did not read one");

	sample_edge_a: assert property (
		$past(q.busy) && $changed(spi_sclk)
		&& ((spi_sclk != q.ctrl[SPM_CTRL_CLOCK_IDLE_LEVEL]) == !clock_sample_edge) |-> q.rxsh[0] == $past(spi_miso))
		else $error("data not sampled on the selected edge");

	half_period_a: assert property (
		q.busy |-> q.hcnt <= half_lim)
		else $error("half period counter beyond divider limit");

	wcol_set_a: assert property (
		wr_data && tx_full |=> q.wcol)
		else $error("write collision not flagged");

	fifo_flags_a: assert property (
		q.rd_pend && q.idx == SPM_IDX_STAT[7:0]
		|=> hrdata[3:0] == $past({tx_full, tx_empty, rx_full, rx_empty}))
		else $error("status FIFO bits do not match FIFO state");

	count_flag_a: assert property (
		done && q.xfer_cnt == q.ext[SPM_EXT_CNT +: 2] |=> q.irq_flag)
		else $error("interrupt flag missed after transfer count");

	disabled_idle_a: assert property (
		!q.busy && !q.ext[SPM_EXT_EN] |=> !q.busy)
		else $error("transfer started while disabled");

	idle_level_a: assert property (
		!q.busy |-> spi_sclk == q.ctrl[SPM_CTRL_CLOCK_IDLE_LEVEL])
		else $error("serial clock not at idle level");

	byte_len_a: assert property (
		$fell(q.busy) |-> $past(q.edge_n) == SPM_LAST_EDGE)
		else $error("transfer ended before sixteen clock edges");

	xfer_done_c: cover property (done);
	wcol_c:      cover property (evt_wcol);
	irq_c:       cover property ($rose(irq));
	rx_full_c:   cover property (rx_full && q.ext[SPM_EXT_CNT +: 2] == 2'h3);
endmodule // spm_spi_master

// ### dv/spm_slave_model.sv
// spm_slave_model: behavioural SPI slave on the far side of the serial link
module spm_slave_model (
	input  wire logic       rst_n,   // model reset, active low
	input  wire logic       sclk,    // serial clock from master
	input  wire logic       mosi,    // data from master
	input  wire logic       clock_idle_level,    // idle level in use
	input  wire logic       clock_sample_edge,    // edge select in use
	input  wire logic [7:0] tx_byte, // byte sent back
	output logic            miso,    // data to master
	output logic      [7:0] rx_byte, // last byte taken
	output logic            rx_tgl   // flips once per byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int         lev = 0;
	int         ret = 0;
	logic [7:0] sh;
	initial rx_tgl = 1'b0;
	// before the first shift edge of phase 1 the line carries junk, never data
	assign miso = clock_sample_edge ? ((lev == 0) ? ~tx_byte[0] : tx_byte[3'(8 - lev)])
		: tx_byte[3'(7 - ret)];
	always @(posedge sclk or negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			lev = 0;
			ret = 0;
		end else if (sclk !== clock_idle_level) begin
			lev = lev + 1;
			if (!clock_sample_edge)
				sh = {sh[6:0], mosi};
		end else begin
			ret = ret + 1;
			if (clock_sample_edge)
				sh = {sh[6:0], mosi};
			if (ret == 8) begin
				rx_byte = sh;
				rx_tgl = ~rx_tgl;
				lev = 0;
				ret = 0;
			end
		end
	end
endmodule // spm_slave_model

// ### dv/spm_spi_master_tb.sv
// spm_spi_master_tb: self-checking bench of the SPI master and its registers
module spm_spi_master_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spm_pkg::*;
	logic          clk, rst_n, hsel, hwrite, hrdy, hresp, irq, sclk, mosi, miso;
	logic          s_rst_n, s_clock_idle_level, s_clock_sample_edge, s_tgl;
	logic          rd_pend = 1'b0;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [31:0]   haddr, hwdata, hrdata;
	logic [7:0]    s_tx, s_rx, rv, d;
	int            n_fail = 0, total_checks = 0, seed = 96, h;
	logic [31:0]   exp_q[$];
	string         nm_q[$];
	logic [7:0]    mo_q[$];
	localparam int DIVS[8] = '{2, 4, 16, 32, 8, 64, 128, 256};

	spm_spi_master uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
		.hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .irq(irq), .spi_sclk(sclk),
		.spi_mosi(mosi), .spi_miso(miso));
	spm_slave_model slv (.rst_n(s_rst_n), .sclk(sclk), .mosi(mosi), .clock_idle_level(s_clock_idle_level),
		.clock_sample_edge(s_clock_sample_edge), .tx_byte(s_tx), .miso(miso), .rx_byte(s_rx), .rx_tgl(s_tgl));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic fail_to(input string w);
		chk(w, 32'h1, 32'h0);
		report_and_stop();
	endtask

	task automatic edge_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 100);
		if (hrdy !== 1'b1)
			fail_to("bus wait");
	endtask

	task automatic bus(input logic w, input logic [31:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {idx[29:0], 2'h0};
		hsize <= 3'h2;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		edge_rdy();
		rv = hrdata[7:0];
	endtask

	// an empty name marks a polling read whose value is not compared
	task automatic ex(input logic [31:0] idx, input string nm, input logic [7:0] e);
		nm_q.push_back(nm);
		exp_q.push_back({24'h0, e});
		bus(1'b0, idx, 8'h00);
	endtask

	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		do begin
			ex(SPM_IDX_STAT, "", 8'h00);
			n++;
		end while ((rv & m) !== v && n < 3000);
		if ((rv & m) !== v)
			fail_to("status wait");
	endtask

	task automatic half(output int n);
		logic s;
		int k;
		s = sclk;
		k = 0;
		while (sclk === s && k < 3000) begin
			@(posedge clk);
			k++;
		end
		s = sclk;
		n = 0;
		while (sclk === s && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (k >= 3000 || n >= 3000)
			fail_to("sclk wait");
	endtask

	// the idle level moves with the write, so the slave restarts its bit count
	task automatic mode(input logic [7:0] c);
		bus(1'b1, SPM_IDX_CTRL, c);
		s_clock_idle_level <= c[3];
		s_clock_sample_edge <= c[2];
		s_rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		s_rst_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic xfer(input int hp);
		s_tx <= 8'($random(seed));
		d = 8'($random(seed));
		mo_q.push_back(d);
		bus(1'b1, SPM_IDX_DATA, d);
		half(h);
		chk("half period", hp, h);
		poll(8'h01, 8'h00);
		ex(SPM_IDX_DATA, "rx data", s_tx);
	endtask

	task automatic irq_is(input logic e);
		@(posedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask

	always @(posedge clk) begin
		if (rd_pend && hrdy === 1'b1) begin
			rd_pend = 1'b0;
			chk("hresp", 32'h0, {31'h0, hresp});
			if (nm_q[0] != "")
				chk(nm_q[0], exp_q[0], hrdata);
			void'(nm_q.pop_front());
			void'(exp_q.pop_front());
		end
		if (hsel && htrans[1] && !hwrite && hrdy === 1'b1)
			rd_pend = 1'b1;
	end

	always @(posedge s_tgl or negedge s_tgl)
		if (rst_n === 1'b1)
			chk("mosi byte", mo_q.size() ? {24'h0, mo_q.pop_front()} : 32'h100,
				{24'h0, s_rx});

	initial begin
		repeat (100000) @(posedge clk);
		fail_to("run time");
	end

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		s_rst_n = 1'b0;
		s_clock_idle_level = 1'b0;
		s_clock_sample_edge = 1'b0;
		s_tx = 8'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		s_rst_n <= 1'b1;
		@(posedge clk);
		ex(SPM_IDX_CTRL, "control", 8'h10);
		ex(SPM_IDX_STAT, "status", 8'h05);
		ex(SPM_IDX_EXT, "extended", 8'h00);
		ex(SPM_IDX_MASK, "mask", 8'hC0);
		ex(32'h50000021, "unmapped", 8'h00);
		bus(1'b1, SPM_IDX_CTRL, 8'hFF);
		ex(SPM_IDX_CTRL, "control", 8'h9F);
		mode(8'h00);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			d = 8'($random(seed));
			if (i < 4)
				mo_q.push_back(d);
			bus(1'b1, SPM_IDX_DATA, d);
		end
		ex(SPM_IDX_STAT, "status", 8'h49);
		bus(1'b1, SPM_IDX_STAT, 8'h40);
		bus(1'b1, SPM_IDX_EXT, 8'h07);
		repeat (20) @(posedge clk);
		ex(SPM_IDX_STAT, "status", 8'h09);
		chk("idle sclk", 32'h0, {31'h0, sclk});
		s_tx <= 8'h5A;
		bus(1'b1, SPM_IDX_EXT, 8'h04);
		poll(8'h06, 8'h06);
		ex(SPM_IDX_STAT, "status", 8'h86);
		for (int i = 0; i < 4; i++)
			ex(SPM_IDX_DATA, "rx data", 8'h5A);
		ex(SPM_IDX_STAT, "status", 8'h85);
		$display("test fifos done");
		for (int i = 0; i < 8; i++) begin
			mode({4'h0, i[0], i[1], i[1:0]});
			chk("idle sclk", {31'h0, i[0]}, {31'h0, sclk});
			bus(1'b1, SPM_IDX_EXT, {5'h0, 1'b1, 1'b0, i[2]});
			xfer(DIVS[i] / 2);
		end
		// extended select 10 with standard 00 divides by 512
		mode(8'h00);
		bus(1'b1, SPM_IDX_EXT, 8'h06);
		xfer(256);
		$display("test modes done");
		bus(1'b1, SPM_IDX_STAT, 8'hC0);
		mode(8'h80);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, SPM_IDX_EXT, {c[1:0], 6'h04});
			for (int k = 0; k <= c; k++) begin
				irq_is(1'b0);
				xfer(1);
			end
			ex(SPM_IDX_STAT, "status", 8'h85);
			irq_is(1'b1);
			bus(1'b1, SPM_IDX_CTRL, 8'h00);
			irq_is(1'b0);
			bus(1'b1, SPM_IDX_MASK, 8'h40);
			bus(1'b1, SPM_IDX_CTRL, 8'h80);
			irq_is(1'b0);
			bus(1'b1, SPM_IDX_MASK, 8'hC0);
			irq_is(1'b1);
			bus(1'b1, SPM_IDX_STAT, 8'h80);
			irq_is(1'b0);
		end
		// a collision alone must raise the interrupt through mask bit 6
		bus(1'b1, SPM_IDX_EXT, 8'h00);
		for (int i = 0; i < 5; i++)
			bus(1'b1, SPM_IDX_DATA, 8'($random(seed)));
		irq_is(1'b1);
		bus(1'b1, SPM_IDX_STAT, 8'h40);
		irq_is(1'b0);
		$display("test interrupts done");
		report_and_stop();
	end
endmodule // spm_spi_master_tb
